// >>> pkg/sbp_defines.svh
// Constants for the status byte port: widths, depths, codes and characters
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH

`define SBP_DATA_W      8
`define SBP_FIFO_DEPTH  16
`define SBP_FIFO_AW     4
`define SBP_DIE_COUNT   2

// Two-hex-digit state codes carried in state change reports
`define SBP_CODE_IDLE   8'h00
`define SBP_CODE_INIT   8'h01
`define SBP_CODE_OBS    8'h02
`define SBP_CODE_CORR   8'h04
`define SBP_CODE_CLASS  8'h08
`define SBP_CODE_INJ    8'h10
`define SBP_CODE_FATAL  8'h1F

// ASCII characters of a report line and the index of its last one
`define SBP_CHR_S       8'h53
`define SBP_CHR_C       8'h43
`define SBP_CHR_SP      8'h20
`define SBP_CHR_CR      8'h0D
`define SBP_CHR_0       8'h30
`define SBP_CHR_A_M10   8'h37
`define SBP_RPT_LAST    3'h5

`endif

// >>> pkg/sbp_pkg.sv
// Types shared by the status byte port design
package sbp_pkg;
    typedef enum logic [1:0] {mode_idle, mode_init, mode_run} sbp_mode_t;
endpackage

// >>> design/sbp_monitor_port.sv
// Controller end of the byte-wide status port with transmit staging FIFO
//
// Overview of operation
// R1: Write a byte only while transmit-full is low, one strobe per byte.
// R2: Back-to-back write strobes allowed, still gated by transmit-full every cycle.
// R3: Peripheral raises transmit-full the cycle after a write that fills it.
// R4: Peripheral raises transmit-full only because of a controller write.
// R5: Pending bytes with transmit-full high stall the controller and block return.
// R6: Peripheral should size buffer and drain rate so stalls stay rare.
// R7: Read a byte only while receive-empty is low, strobe acknowledges it.
// R8: Back-to-back read strobes allowed, still gated by receive-empty every cycle.
// R9: Peripheral raises receive-empty the cycle after a read that emptied it.
// R10: Peripheral raises receive-empty only because of a controller read.
// R11: Initialization reads and discards received bytes until receive-empty.
// R12: Transmit side is treated as ready right after initialization.
// R13: Supervisor watches heartbeats; a silent heartbeat in observation is a fault.
// R14: Supervisor monitors every die region heartbeat.
// R15: CRC failure indicator asserts on detected CRC failures, transients expected.
// R16: Supervisor flags a fault if CRC failure persists without correction.
// R17: Per-die CRC failure indicators are wire-ORed onto one open-drain pin.
// R18: Replacement buffers: one clock, fall-through, eight bits wide.
// R19: Data-present indication is inverted to form the empty flag.
// R20: All bytes on the port are ASCII text commands and reports.
// R21: Every state change emits an SC line with the two-hex-digit state code; changes during a report line yield one line with the latest code.
// R22: Both strobes stay low after reset until initialization begins.
`timescale 1ns/1ns

`include "sbp_defines.svh"

// Synchronous first-word fall-through FIFO held in flip-flops
module sbp_fifo #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   count_ff;
    logic [AW:0]   nxt_count;
    wire           push;
    wire           pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (count_ff != (AW+1)'(D));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

    // Pointers wrap naturally only when the depth is a power of two
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end
        else
        begin
            wr_ptr_ff <= push ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
            count_ff  <= nxt_count;
        end
    end

    // One storage word per entry, written when the write pointer selects it
    for (genvar i = 0; i < D; i++)
    begin : g_entry
        always_ff @(posedge ref_clk)
        begin
            if (push && (wr_ptr_ff == AW'(i)))
            begin
                mem_ff[i] <= in_data;
            end
        end
    end
endmodule

// Controller side of the port: init purge, state reports, stream, health pins
module sbp_monitor_port (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        init_req,
    input  wire logic [7:0]                  core_state,
    input  wire logic                        usr_tx_valid,
    output logic                             usr_tx_ready,
    input  wire logic [`SBP_DATA_W-1:0]      usr_tx_data,
    output logic [`SBP_DATA_W-1:0]           usr_rx_data,
    output logic                             usr_rx_valid,
    output logic                             init_busy,
    output logic                             init_done,
    output logic                             tx_stalled,
    input  wire logic                        tx_full,
    output logic [`SBP_DATA_W-1:0]           tx_data,
    output logic                             tx_write,
    input  wire logic                        rx_empty,
    input  wire logic [`SBP_DATA_W-1:0]      rx_data,
    output logic                             rx_read,
    input  wire logic [`SBP_DIE_COUNT-1:0]   die_region_crc_err,
    input  wire logic                        crc_fail_pin_in,
    output logic                             crc_fail_pin_out,
    output logic                             crc_fail_pin_oe_n,
    output logic                             crc_fail_seen,
    input  wire logic [`SBP_DIE_COUNT-1:0]   die_region_readback,
    output logic [`SBP_DIE_COUNT-1:0]        die_region_heartbeat
);
    sbp_pkg::sbp_mode_t         mode_ff;
    sbp_pkg::sbp_mode_t         nxt_mode;
    logic [7:0]                 last_code_ff;
    logic [7:0]                 rpt_code_ff;
    logic                       rpt_active_ff;
    logic [2:0]                 rpt_idx_ff;
    logic [`SBP_DATA_W-1:0]     rx_byte_ff;
    logic                       rx_valid_ff;
    logic                       init_done_ff;
    logic                       crc_seen_ff;
    logic [`SBP_DIE_COUNT-1:0]  hb_ff;
    logic [`SBP_DATA_W-1:0]     rpt_byte;
    logic [7:0]                 cur_code;
    wire                        fifo_in_valid;
    wire                        fifo_in_ready;
    wire [`SBP_DATA_W-1:0]      fifo_in_data;
    wire                        fifo_out_valid;
    wire [`SBP_DATA_W-1:0]      fifo_out_data;
    wire                        tx_go;
    wire                        rx_go;
    wire                        purge_end;
    wire                        code_changed;
    wire                        rpt_push;
    wire                        port_open;

    // Upper-case ASCII hex digit of a nibble
    function automatic logic [7:0] hex_chr(input logic [3:0] nib);
        logic [7:0] base;
        base = (nib > 4'h9) ? `SBP_CHR_A_M10 : `SBP_CHR_0;
        return base + {4'h0, nib};
    endfunction

    // Code reported to the supervisor follows our own mode, then the core's
    assign cur_code = (mode_ff == sbp_pkg::mode_idle) ? `SBP_CODE_IDLE :
                      (mode_ff == sbp_pkg::mode_init) ? `SBP_CODE_INIT : core_state;
    assign code_changed = (cur_code != last_code_ff) && !rpt_active_ff; // see R21

    // Report line "SC hh" plus carriage return, one character per push
    always_comb
    begin
        case (rpt_idx_ff)
            3'h0:    rpt_byte = `SBP_CHR_S;
            3'h1:    rpt_byte = `SBP_CHR_C;
            3'h2:    rpt_byte = `SBP_CHR_SP;
            3'h3:    rpt_byte = hex_chr(rpt_code_ff[7:4]);
            3'h4:    rpt_byte = hex_chr(rpt_code_ff[3:0]);
            default: rpt_byte = `SBP_CHR_CR;
        endcase
    end

    // Reports take the FIFO input ahead of the user stream
    assign rpt_push      = rpt_active_ff && fifo_in_ready;
    assign fifo_in_valid = rpt_active_ff || usr_tx_valid;
    assign fifo_in_data  = rpt_active_ff ? rpt_byte : usr_tx_data; // see R20
    assign usr_tx_ready  = fifo_in_ready && !rpt_active_ff;

    // Staging buffer between report sources and the port
    sbp_fifo #(
        .W  (`SBP_DATA_W),
        .D  (`SBP_FIFO_DEPTH),
        .AW (`SBP_FIFO_AW)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (tx_go),
        .out_data  (fifo_out_data)
    );

    // Both strobes stay quiet in idle, so nothing moves before init begins
    assign port_open  = (mode_ff != sbp_pkg::mode_idle); // see R22

    // Transmit: one byte per cycle while full stays low outside idle, bursts allowed
    assign tx_go      = fifo_out_valid && !tx_full && port_open; // see R1 R2 R22
    assign tx_write   = tx_go;
    assign tx_data    = fifo_out_data;
    assign tx_stalled = fifo_out_valid && tx_full; // see R5
    // Transmit is open as soon as init starts; the far buffer cannot be seen. see R12

    // Receive: read whenever a byte is present outside idle, purge or deliver
    assign rx_go     = !rx_empty && port_open; // see R7 R8 R22
    assign rx_read   = rx_go;
    assign purge_end = (mode_ff == sbp_pkg::mode_init) && rx_empty; // see R11

    // Mode sequencing; init waits only for the receive side to drain
    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            sbp_pkg::mode_idle: nxt_mode = init_req ? sbp_pkg::mode_init : mode_ff;
            sbp_pkg::mode_init: nxt_mode = purge_end ? sbp_pkg::mode_run : mode_ff;
            sbp_pkg::mode_run:  nxt_mode = mode_ff;
            default:            nxt_mode = sbp_pkg::mode_idle;
        endcase
    end

    // Mode register; init_done pulses once, the cycle after the purge ends
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mode_ff      <= sbp_pkg::mode_idle;
            init_done_ff <= 1'b0;
        end
        else
        begin
            mode_ff      <= nxt_mode;
            init_done_ff <= purge_end;
        end
    end

    // State change report sequencer
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            last_code_ff  <= `SBP_CODE_IDLE;
            rpt_code_ff   <= `SBP_CODE_IDLE;
            rpt_active_ff <= 1'b0;
            rpt_idx_ff    <= 3'h0;
        end
        else if (code_changed)
        begin
            last_code_ff  <= cur_code;
            rpt_code_ff   <= cur_code; // see R21
            rpt_active_ff <= 1'b1;
            rpt_idx_ff    <= 3'h0;
        end
        else if (rpt_push)
        begin
            rpt_active_ff <= (rpt_idx_ff != `SBP_RPT_LAST);
            rpt_idx_ff    <= rpt_idx_ff + 3'h1;
        end
    end

    // Received bytes reach the user only after the purge; purged ones drop
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rx_byte_ff  <= 8'h00;
            rx_valid_ff <= 1'b0;
        end
        else
        begin
            rx_valid_ff <= rx_go && (mode_ff == sbp_pkg::mode_run); // see R11
            rx_byte_ff  <= rx_go ? rx_data : rx_byte_ff;
        end
    end

    // Status outputs straight from registers and the mode
    assign usr_rx_data  = rx_byte_ff;
    assign usr_rx_valid = rx_valid_ff;
    assign init_busy    = (mode_ff == sbp_pkg::mode_init);
    assign init_done    = init_done_ff;

    // Open-drain CRC failure pin: any die region pulls it low (wire-OR)
    assign crc_fail_pin_out  = 1'b0;
    assign crc_fail_pin_oe_n = ~(|die_region_crc_err); // see R15 R17

    // Pin level read back, so a failure from any die shows here too
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            crc_seen_ff <= 1'b0;
        end
        else
        begin
            crc_seen_ff <= !crc_fail_pin_in;
        end
    end

    assign crc_fail_seen = crc_seen_ff;

    // One registered heartbeat output per die region, never merged
    for (genvar d = 0; d < `SBP_DIE_COUNT; d++)
    begin : g_die
        always_ff @(posedge ref_clk)
        begin
            if (!rst_n)
            begin
                hb_ff[d] <= 1'b0;
            end
            else
            begin
                hb_ff[d] <= die_region_readback[d];
            end
        end
    end

    assign die_region_heartbeat = hb_ff;
endmodule

// >>> tb/sbp_monitor_port_asserts.sv
// Checker for the status byte port controller
`timescale 1ns/1ns
module sbp_port_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       tx_full,
    input wire logic       tx_write,
    input wire logic       tx_stalled,
    input wire logic       rx_empty,
    input wire logic [7:0] rx_data,
    input wire logic       rx_read,
    input wire logic       init_busy,
    input wire logic       init_done,
    input wire logic       usr_rx_valid,
    input wire logic [7:0] usr_rx_data,
    input wire logic [1:0] die_region_crc_err,
    input wire logic       crc_fail_pin_in,
    input wire logic       crc_fail_pin_oe_n,
    input wire logic       crc_fail_seen,
    input wire logic [1:0] die_region_readback,
    input wire logic [1:0] die_region_heartbeat
);
    // One clock domain, so clock and reset are given once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_wr_gate; tx_write |-> !tx_full; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write while full");
    property p_stall; tx_stalled |-> tx_full && !tx_write; endproperty
    a_stall: assert property (p_stall) else $error("stall flag wrong");
    property p_rd_gate; rx_read |-> !rx_empty; endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read while empty");
    property p_quiet; $rose(rst_n) |-> !tx_write && !rx_read; endproperty
    a_quiet: assert property (p_quiet) else $error("strobe after reset");
    property p_purge; init_busy && !rx_empty |-> rx_read; endproperty
    a_purge: assert property (p_purge) else $error("purge skipped a byte");
    property p_init_end; init_busy && rx_empty |=> init_done && !init_busy; endproperty
    a_init_end: assert property (p_init_end) else $error("init did not end");
    // Purged bytes never reach the user side
    property p_drop; init_busy && rx_read |=> !usr_rx_valid; endproperty
    a_drop: assert property (p_drop) else $error("purged byte forwarded");
    property p_fwd; rx_read && !init_busy |=> usr_rx_valid && usr_rx_data == $past(rx_data);
    endproperty
    a_fwd: assert property (p_fwd) else $error("received byte lost");
    property p_tx_ready; $rose(init_busy) |-> ##[0:8] tx_write; endproperty
    a_tx_ready: assert property (p_tx_ready) else $error("no send after init");
    property p_crc_pin; !crc_fail_pin_oe_n == (|die_region_crc_err); endproperty
    a_crc_pin: assert property (p_crc_pin) else $error("fail pin wrong");
    property p_crc_seen; !crc_fail_pin_in |=> crc_fail_seen; endproperty
    a_crc_seen: assert property (p_crc_seen) else $error("fail not seen");
    property p_beat; 1'b1 |=> die_region_heartbeat == $past(die_region_readback); endproperty
    a_beat: assert property (p_beat) else $error("heartbeat lost");
endmodule

// >>> tb/sbp_periph_model.sv
// Behavioural peripheral with small transmit and receive buffers
`timescale 1ns/1ns
module sbp_periph_model #(
    parameter int TXD = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_write,
    input  wire logic [7:0] tx_data,
    output logic            tx_full,
    input  wire logic       rx_read,
    output logic [7:0]      rx_data,
    output logic            rx_empty,
    input  wire logic       drain_en,
    input  wire logic       load_vld,
    input  wire logic [7:0] load_data,
    output logic            out_vld,
    output logic [7:0]      out_data
);
    logic [7:0] tq[$];
    logic [7:0] rq[$];

    // Drain only lowers full, so full can rise only from a write
    // Empty rises only after a read takes the last byte
    always @(posedge ref_clk)
    begin
        out_vld <= 1'b0;
        if (!rst_n)
        begin
            tq.delete();
            rq.delete();
        end
        else
        begin
            if (drain_en && tq.size() > 0)
            begin
                out_vld <= 1'b1;
                out_data <= tq.pop_front();
            end
            if (tx_write)
                tq.push_back(tx_data);
            if (rx_read && rq.size() > 0)
                void'(rq.pop_front());
            if (load_vld)
                rq.push_back(load_data);
        end
        tx_full <= (tq.size() >= TXD);
        rx_empty <= (rq.size() == 0);
        // An empty buffer inverts its last value each cycle, from 00 in reset, so the old byte recurs every other cycle
        rx_data <= (rq.size() > 0) ? rq[0] : (rst_n ? ~rx_data : 8'h00);
    end
endmodule

// >>> tb/sbp_monitor_port_bench.sv
// Self-checking bench for the status byte port controller
`timescale 1ns/1ns
module sbp_monitor_port_bench;
    logic       ref_clk, rst_n, init_req, usr_tx_valid, drain_en, load_vld, acc;
    logic [7:0] core_state, usr_tx_data, load_data, usr_rx_data, tx_data, rx_data, out_data;
    logic       usr_tx_ready, usr_rx_valid, init_busy, init_done, tx_stalled, tx_full;
    logic       tx_write, rx_empty, rx_read, pin_out, pin_oe_n, crc_seen, out_vld;
    logic [1:0] crc_err, readback, heartbeat;
    logic [31:0] seed = 32'h115E6;
    logic [7:0] exp_tx[$], exp_rx[$];
    logic [7:0] codes[5] = '{8'h04, 8'h08, 8'h10, 8'h1F, 8'h00};
    int         error_cnt, total_checks;
    // Open-drain fail pin with its pull-up
    wire logic  crc_pin = pin_oe_n ? 1'b1 : pin_out;

    sbp_monitor_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .init_req(init_req),
        .core_state(core_state), .usr_tx_valid(usr_tx_valid), .usr_tx_ready(usr_tx_ready),
        .usr_tx_data(usr_tx_data), .usr_rx_data(usr_rx_data), .usr_rx_valid(usr_rx_valid),
        .init_busy(init_busy), .init_done(init_done), .tx_stalled(tx_stalled),
        .tx_full(tx_full), .tx_data(tx_data), .tx_write(tx_write), .rx_empty(rx_empty),
        .rx_data(rx_data), .rx_read(rx_read), .die_region_crc_err(crc_err),
        .crc_fail_pin_in(crc_pin), .crc_fail_pin_out(pin_out),
        .crc_fail_pin_oe_n(pin_oe_n), .crc_fail_seen(crc_seen),
        .die_region_readback(readback), .die_region_heartbeat(heartbeat));
    sbp_periph_model #(.TXD(4)) pm (.ref_clk(ref_clk), .rst_n(rst_n), .tx_write(tx_write),
        .tx_data(tx_data), .tx_full(tx_full), .rx_read(rx_read), .rx_data(rx_data),
        .rx_empty(rx_empty), .drain_en(drain_en), .load_vld(load_vld),
        .load_data(load_data), .out_vld(out_vld), .out_data(out_data));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] hx(logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #2;
    endtask
    // Expected report line: S, C, space, two hex digits, carriage return
    task automatic line(logic [7:0] c);
        exp_tx = {exp_tx, 8'h53, 8'h43, 8'h20, hx(c[7:4]), hx(c[3:0]), 8'h0D};
    endtask
    task automatic drained();
        for (int i = 0; i < 300 && exp_tx.size() > 0; i++)
            tick();
        chk("bytes left", 8'(exp_tx.size()), 8'h00);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Oldest note is taken off as each result appears
    always @(posedge ref_clk)
        if (rst_n)
        begin
            if (out_vld === 1'b1)
                chk("tx byte", out_data, exp_tx.size() ? exp_tx.pop_front() : 8'hXX);
            if (usr_rx_valid === 1'b1)
                chk("rx byte", usr_rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hXX);
        end
    // Whole run needs well under ten thousand cycles
    initial
    begin
        #500000;
        error_cnt++;
        $display("timeout");
        test_done();
    end

    initial
    begin
        {init_req, usr_tx_valid, load_vld, usr_tx_data, load_data, crc_err, readback} = '0;
        {rst_n, drain_en, core_state} = {1'b0, 1'b1, 8'h02};
        repeat (8) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        // Stale bytes are purged while the init report goes out, then the run report follows
        for (int i = 0; i < 3; i++)
        begin
            load_vld = 1'b1;
            load_data = rnd();
            tick();
        end
        load_vld = 1'b0;
        chk("idle strobes", 8'({tx_write, rx_read}), 8'h00);
        line(8'h01);
        line(8'h02);
        init_req = 1'b1;
        tick();
        init_req = 1'b0;
        for (int i = 0; i < 50 && init_done !== 1'b1; i++)
            tick();
        chk("init done", 8'(init_done), 8'h01);
        drained();
        $display("test init done");
        // Back-to-back receive burst
        for (int i = 0; i < 8; i++)
        begin
            load_vld = 1'b1;
            load_data = rnd();
            exp_rx.push_back(load_data);
            tick();
        end
        load_vld = 1'b0;
        repeat (4) tick();
        chk("rx left", 8'(exp_rx.size()), 8'h00);
        $display("test receive done");
        // Far side stalls: FIFO and peripheral buffer fill until refused
        drain_en = 1'b0;
        usr_tx_valid = 1'b1;
        usr_tx_data = rnd() & 8'h7F;
        for (int i = 0; i < 30; i++)
        begin
            @(negedge ref_clk);
            acc = usr_tx_ready;
            if (acc)
                exp_tx.push_back(usr_tx_data);
            tick();
            if (acc)
                usr_tx_data = rnd() & 8'h7F;
        end
        usr_tx_valid = 1'b0;
        chk("accepted", 8'(exp_tx.size()), 8'h14);
        chk("stalled", 8'(tx_stalled), 8'h01);
        drain_en = 1'b1;
        drained();
        $display("test stall done");
        // Every remaining state code is reported once
        foreach (codes[i])
        begin
            core_state = codes[i];
            line(codes[i]);
            drained();
        end
        $display("test codes done");
        // Fail pin and heartbeat follow random per-die inputs
        for (int i = 0; i < 16; i++)
        begin
            {crc_err, readback} = 4'(rnd());
            tick();
            chk("pin oe", 8'(pin_oe_n), 8'(crc_err == 2'b00));
            chk("fail seen", 8'(crc_seen), 8'(crc_err != 2'b00));
            chk("heartbeat", 8'(heartbeat), 8'(readback));
        end
        $display("test health done");
        test_done();
    end
endmodule

bind sbp_monitor_port sbp_port_chk chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .tx_full(tx_full), .tx_write(tx_write), .tx_stalled(tx_stalled), .rx_empty(rx_empty),
    .rx_data(rx_data), .rx_read(rx_read), .init_busy(init_busy), .init_done(init_done),
    .usr_rx_valid(usr_rx_valid), .usr_rx_data(usr_rx_data),
    .die_region_crc_err(die_region_crc_err), .crc_fail_pin_in(crc_fail_pin_in),
    .crc_fail_pin_oe_n(crc_fail_pin_oe_n), .crc_fail_seen(crc_fail_seen),
    .die_region_readback(die_region_readback), .die_region_heartbeat(die_region_heartbeat));
